// [logic/tpc_pkg.sv]
/*
  Package for the timer pin routing and byte buffer register bank.
  Holds register offsets, variant codes, reset values and field positions.
  Assumes an APB slave with 32-bit data and word-aligned registers.
*/
package tpc_pkg;

  // ************************************************************
  // Register byte offsets (one aligned word each)
  // ************************************************************
  localparam logic [7:0] OFF_ROUTE0 = 8'h00; // First pin routing register
  localparam logic [7:0] OFF_ROUTE1 = 8'h04; // Second pin routing register
  localparam logic [7:0] OFF_CNT_LO = 8'h08; // Counter low byte, via buffer
  localparam logic [7:0] OFF_CNT_HI = 8'h0C; // Counter high byte
  localparam logic [7:0] OFF_CMPA_LO = 8'h10; // Compare A low byte, via buffer
  localparam logic [7:0] OFF_CMPA_HI = 8'h14; // Compare A high byte
  localparam logic [7:0] OFF_CMPB_LO = 8'h18; // Compare B low byte, via buffer
  localparam logic [7:0] OFF_CMPB_HI = 8'h1C; // Compare B high byte

  // ************************************************************
  // Device variants
  // ************************************************************
  localparam int VAR_SMALL = 0; // One compact, one standard timer
  localparam int VAR_TWO = 1; // Enhanced timer with two B outputs
  localparam int VAR_THREE = 2; // Three timers, three B outputs
  localparam int VAR_FOUR = 3; // Four timers

  // ************************************************************
  // Implemented bit masks and reset values per variant
  // ************************************************************
  localparam logic [7:0] MASK0_SMALL = 8'h31;
  localparam logic [7:0] RST0_SMALL = 8'h11;
  localparam logic [7:0] MASK0_TWO = 8'hB3;
  localparam logic [7:0] MASK0_WIDE = 8'hF3;
  localparam logic [7:0] RST0_LARGE = 8'h91;
  localparam logic [7:0] MASK1_NONE = 8'h00;
  localparam logic [7:0] MASK1_THREE = 8'h03;
  localparam logic [7:0] MASK1_FOUR = 8'h33;
  localparam logic [7:0] RST1_THREE = 8'h01;
  localparam logic [7:0] RST1_FOUR = 8'h11;
  localparam logic [7:0] VALUE_RST = 8'h00; // Byte buffer reset value

  // Pin enable outputs grouped as one carrier
  typedef struct packed {
    logic enhOutA;
    logic enhOutB2;
    logic enhOutB1;
    logic enhOutB0;
    logic timer0Out1;
    logic timer0Out0;
    logic timer1Out1;
    logic timer1Out0;
    logic timer2Out1;
    logic timer2Out0;
    logic timer3Out1;
    logic timer3Out0;
  } tpc_pins_s;

endpackage : tpc_pkg

// [logic/tpc_bank.sv]
/*
  Timer pin routing registers and buffered counter/compare byte access.
  Assumes an APB master, one clock, and a timer core that supplies the live
  counter value and consumes the compare values.
*/
// Operation
// - Set bit routes pin to timer
// - Implemented routing bits read and write
// - Unimplemented routing bits read zero
// - Small variant layout and reset values
// - Larger variants layout and reset values
// - Second register layout and reset values
// - Wide values split into high, low
// - Buffer moves only on high read or low compare write
// - Low compare write fills buffer only
// - High compare write copies buffer low
// - High read captures low into buffer
// - Low read returns buffer contents
`timescale 1ns/10ps
module tpc_bank #(
  parameter int VARIANT = tpc_pkg::VAR_FOUR, // Device variant
  parameter int VALUE_W = 16 // Counter and compare width, 10 or 16
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [VALUE_W-1:0] countValue,
  output logic [VALUE_W-1:0] compareAValue,
  output logic [VALUE_W-1:0] compareBValue,
  output tpc_pkg::tpc_pins_s pinEnable
);

  // ************************************************************
  // Variant decode
  // ************************************************************
  localparam logic [7:0] MASK0 = (VARIANT == tpc_pkg::VAR_SMALL) ? tpc_pkg::MASK0_SMALL :
    (VARIANT == tpc_pkg::VAR_TWO) ? tpc_pkg::MASK0_TWO : tpc_pkg::MASK0_WIDE;
  localparam logic [7:0] RST0 = (VARIANT == tpc_pkg::VAR_SMALL) ? tpc_pkg::RST0_SMALL :
    tpc_pkg::RST0_LARGE;
  localparam logic [7:0] MASK1 = (VARIANT == tpc_pkg::VAR_FOUR) ? tpc_pkg::MASK1_FOUR :
    (VARIANT == tpc_pkg::VAR_THREE) ? tpc_pkg::MASK1_THREE : tpc_pkg::MASK1_NONE;
  localparam logic [7:0] RST1 = (VARIANT == tpc_pkg::VAR_FOUR) ? tpc_pkg::RST1_FOUR :
    (VARIANT == tpc_pkg::VAR_THREE) ? tpc_pkg::RST1_THREE : tpc_pkg::MASK1_NONE;
  localparam int HI_W = VALUE_W - 8; // High byte width
  localparam logic [7:0] RST0_M = RST0 & MASK0;
  localparam logic [7:0] RST1_M = RST1 & MASK1;

  // ************************************************************
  // State
  // ************************************************************
  logic [7:0] route0; // First routing register
  logic [7:0] route1; // Second routing register
  logic [7:0] byteBuffer; // Shared low byte buffer
  logic accessDone; // APB access phase completes this edge
  logic wrDone; // Completed write
  logic rdDone; // Completed read
  logic [31:0] next_prdata; // Read mux

  // Zero-wait slave: every access completes in its first access cycle
  assign accessDone = psel & penable;
  assign wrDone = accessDone & pwrite;
  assign rdDone = accessDone & ~pwrite;

  // High byte as an 8-bit readback with zeroes above the implemented width
  function automatic logic [7:0] hiByte(input logic [VALUE_W-1:0] v);
    logic [7:0] r;
    r = 8'h00;
    r[HI_W-1:0] = v[VALUE_W-1:8];
    return r;
  endfunction : hiByte

  // ************************************************************
  // Pin routing registers
  // ************************************************************
  // Masking on write keeps unimplemented positions at zero forever
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      route0 <= RST0_M;
      route1 <= RST1_M;
    end else if (wrDone && paddr == tpc_pkg::OFF_ROUTE0) begin
      route0 <= pwdata[7:0] & MASK0;
    end else if (wrDone && paddr == tpc_pkg::OFF_ROUTE1) begin
      route1 <= pwdata[7:0] & MASK1;
    end
  end

  // Pin enables to the pin multiplexers, one flop stage per bit
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pinEnable <= '0;
    end else if (VARIANT == tpc_pkg::VAR_SMALL) begin
      pinEnable <= '0;
      pinEnable.timer1Out1 <= route0[5];
      pinEnable.timer1Out0 <= route0[4];
      pinEnable.timer0Out0 <= route0[0];
    end else begin
      pinEnable.enhOutA <= route0[7];
      pinEnable.enhOutB2 <= route0[6];
      pinEnable.enhOutB1 <= route0[5];
      pinEnable.enhOutB0 <= route0[4];
      pinEnable.timer0Out1 <= route0[1];
      pinEnable.timer0Out0 <= route0[0];
      pinEnable.timer1Out1 <= 1'b0;
      pinEnable.timer1Out0 <= 1'b0;
      pinEnable.timer2Out1 <= route1[1];
      pinEnable.timer2Out0 <= route1[0];
      pinEnable.timer3Out1 <= route1[5];
      pinEnable.timer3Out0 <= route1[4];
    end
  end

  // ************************************************************
  // Buffered value access
  // ************************************************************
  // The buffer is shared by all pairs, so interleaving two pairs corrupts
  // the result; software must keep each pair's access together.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      byteBuffer <= tpc_pkg::VALUE_RST;
    end else if (wrDone && (paddr == tpc_pkg::OFF_CMPA_LO || paddr == tpc_pkg::OFF_CMPB_LO)) begin
      byteBuffer <= pwdata[7:0];
    end else if (rdDone && paddr == tpc_pkg::OFF_CNT_HI) begin
      byteBuffer <= countValue[7:0];
    end else if (rdDone && paddr == tpc_pkg::OFF_CMPA_HI) begin
      byteBuffer <= compareAValue[7:0];
    end else if (rdDone && paddr == tpc_pkg::OFF_CMPB_HI) begin
      byteBuffer <= compareBValue[7:0];
    end
  end

  // Compare values change only on a high byte write
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      compareAValue <= '0;
      compareBValue <= '0;
    end else if (wrDone && paddr == tpc_pkg::OFF_CMPA_HI) begin
      compareAValue <= {pwdata[HI_W-1:0], byteBuffer};
    end else if (wrDone && paddr == tpc_pkg::OFF_CMPB_HI) begin
      compareBValue <= {pwdata[HI_W-1:0], byteBuffer};
    end
  end

  // ************************************************************
  // APB read data and response
  // ************************************************************
  always_comb begin
    next_prdata = 32'h0000_0000;
    if (paddr == tpc_pkg::OFF_ROUTE0) begin
      next_prdata[7:0] = route0;
    end else if (paddr == tpc_pkg::OFF_ROUTE1) begin
      next_prdata[7:0] = route1;
    end else if (paddr == tpc_pkg::OFF_CNT_LO || paddr == tpc_pkg::OFF_CMPA_LO ||
                 paddr == tpc_pkg::OFF_CMPB_LO) begin
      next_prdata[7:0] = byteBuffer;
    end else if (paddr == tpc_pkg::OFF_CNT_HI) begin
      next_prdata[7:0] = hiByte(countValue);
    end else if (paddr == tpc_pkg::OFF_CMPA_HI) begin
      next_prdata[7:0] = hiByte(compareAValue);
    end else if (paddr == tpc_pkg::OFF_CMPB_HI) begin
      next_prdata[7:0] = hiByte(compareBValue);
    end
  end

  // Registered answer: data and ready appear in the access cycle
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & (paddr > tpc_pkg::OFF_CMPB_HI || paddr[1:0] != 2'b00);
      prdata <= (psel & ~penable & ~pwrite) ? next_prdata : 32'h0000_0000;
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  a_route_reset: assert property (@(posedge clk) $rose(rst_b) |-> route0 == RST0_M && route1 == RST1_M)
    else $error("routing reset value wrong");
  a_route_write: assert property (@(posedge clk) disable iff (!rst_b)
    wrDone && paddr == tpc_pkg::OFF_ROUTE0 |=> route0 == ($past(pwdata[7:0]) & MASK0))
    else $error("routing write lost");
  a_unimpl_zero: assert property (@(posedge clk) disable iff (!rst_b)
    (route0 & ~MASK0) == 8'h00 && (route1 & ~MASK1) == 8'h00)
    else $error("unimplemented bit set");
  a_pin_follow: assert property (@(posedge clk) disable iff (!rst_b)
    $past(rst_b) |-> pinEnable.timer0Out0 == $past(route0[0]))
    else $error("pin enable not following");
  a_low_write_buf: assert property (@(posedge clk) disable iff (!rst_b)
    wrDone && paddr == tpc_pkg::OFF_CMPA_LO |=> byteBuffer == $past(pwdata[7:0])
    && $stable(compareAValue))
    else $error("low write touched compare");
  a_high_write_copy: assert property (@(posedge clk) disable iff (!rst_b)
    wrDone && paddr == tpc_pkg::OFF_CMPB_HI |=> compareBValue[7:0] == $past(byteBuffer))
    else $error("buffer not copied to low byte");
  a_high_read_cap: assert property (@(posedge clk) disable iff (!rst_b)
    rdDone && paddr == tpc_pkg::OFF_CNT_HI |=> byteBuffer == $past(countValue[7:0]))
    else $error("low byte not captured");
  a_buffer_hold: assert property (@(posedge clk) disable iff (!rst_b)
    rdDone && paddr == tpc_pkg::OFF_CNT_LO |=> $stable(byteBuffer))
    else $error("buffer moved on low read");
  a_low_read_buf: assert property (@(posedge clk) disable iff (!rst_b)
    psel && !penable && !pwrite && paddr == tpc_pkg::OFF_CMPA_LO
    |=> prdata[7:0] == $past(byteBuffer))
    else $error("low read not from buffer");

  // ************************************************************
  // Routing register checks
  // ************************************************************
  // Second register keeps only its implemented bits
  a_route1_write: assert property (@(posedge clk) disable iff (!rst_b)
    wrDone && paddr == tpc_pkg::OFF_ROUTE1 |=> route1 == ($past(pwdata[7:0]) & MASK1))
    else $error("second routing write lost");

  // Nothing but a write to its own address may move the first register
  a_route0_hold: assert property (@(posedge clk) disable iff (!rst_b)
    !(wrDone && paddr == tpc_pkg::OFF_ROUTE0) |=> $stable(route0))
    else $error("first routing register moved");

  // Same for the second register
  a_route1_hold: assert property (@(posedge clk) disable iff (!rst_b)
    !(wrDone && paddr == tpc_pkg::OFF_ROUTE1) |=> $stable(route1))
    else $error("second routing register moved");

  // Read of the first register returns the stored bits, upper bytes zero
  a_route0_read: assert property (@(posedge clk) disable iff (!rst_b)
    psel && !penable && !pwrite && paddr == tpc_pkg::OFF_ROUTE0
    |=> prdata == {24'h000000, $past(route0)})
    else $error("first routing readback wrong");

  // Read of the second register shows zero in unused positions
  a_route1_read: assert property (@(posedge clk) disable iff (!rst_b)
    psel && !penable && !pwrite && paddr == tpc_pkg::OFF_ROUTE1
    |=> prdata == {24'h000000, $past(route1)})
    else $error("second routing readback wrong");

  // Unused positions never leak into a first routing register readback
  a_unimpl_read: assert property (@(posedge clk) disable iff (!rst_b)
    psel && !penable && !pwrite && paddr == tpc_pkg::OFF_ROUTE0
    |=> (prdata[7:0] & ~MASK0) == 8'h00)
    else $error("unimplemented bit read back");

  // ************************************************************
  // Pin enable checks
  // ************************************************************
  // Small variant: second timer pins follow bits 5 and 4
  a_pin_small_t1: assert property (@(posedge clk) disable iff (!rst_b)
    $past(rst_b) && VARIANT == tpc_pkg::VAR_SMALL
    |-> {pinEnable.timer1Out1, pinEnable.timer1Out0} == $past(route0[5:4]))
    else $error("small variant timer pins wrong");

  // Small variant: pins of absent timers stay with their other function
  a_pin_small_off: assert property (@(posedge clk) disable iff (!rst_b)
    $past(rst_b) && VARIANT == tpc_pkg::VAR_SMALL
    |-> !pinEnable.enhOutA && !pinEnable.timer2Out0 && !pinEnable.timer3Out0)
    else $error("small variant absent pin enabled");

  // Enhanced timer pins follow the top nibble
  a_pin_enh: assert property (@(posedge clk) disable iff (!rst_b)
    $past(rst_b) && VARIANT != tpc_pkg::VAR_SMALL
    |-> {pinEnable.enhOutA, pinEnable.enhOutB2, pinEnable.enhOutB1,
         pinEnable.enhOutB0} == $past(route0[7:4]))
    else $error("enhanced timer pins wrong");

  // First timer pins follow bits 1 and 0
  a_pin_t0: assert property (@(posedge clk) disable iff (!rst_b)
    $past(rst_b) && VARIANT != tpc_pkg::VAR_SMALL
    |-> {pinEnable.timer0Out1, pinEnable.timer0Out0} == $past(route0[1:0]))
    else $error("first timer pins wrong");

  // Larger variants have no standard second timer pins
  a_pin_t1_off: assert property (@(posedge clk) disable iff (!rst_b)
    $past(rst_b) && VARIANT != tpc_pkg::VAR_SMALL
    |-> !pinEnable.timer1Out1 && !pinEnable.timer1Out0)
    else $error("absent timer pin enabled");

  // Third timer pins follow the low bits of the second register
  a_pin_t2: assert property (@(posedge clk) disable iff (!rst_b)
    $past(rst_b) && VARIANT != tpc_pkg::VAR_SMALL
    |-> {pinEnable.timer2Out1, pinEnable.timer2Out0} == $past(route1[1:0]))
    else $error("third timer pins wrong");

  // Fourth timer pins follow bits 5 and 4 of the second register
  a_pin_t3: assert property (@(posedge clk) disable iff (!rst_b)
    $past(rst_b) && VARIANT != tpc_pkg::VAR_SMALL
    |-> {pinEnable.timer3Out1, pinEnable.timer3Out0} == $past(route1[5:4]))
    else $error("fourth timer pins wrong");

  // One cycle after reset ends the first pin is routed to its timer
  a_pin_after_rst: assert property (@(posedge clk)
    $rose(rst_b) |=> pinEnable.timer0Out0 == RST0_M[0])
    else $error("pin enable reset value wrong");

  // ************************************************************
  // Buffer and value checks
  // ************************************************************
  // Compare B low write fills only the buffer
  a_cmpb_low_buf: assert property (@(posedge clk) disable iff (!rst_b)
    wrDone && paddr == tpc_pkg::OFF_CMPB_LO |=> byteBuffer == $past(pwdata[7:0])
    && $stable(compareBValue))
    else $error("low write touched compare b");

  // Compare A high write commits high bits and buffered low byte together
  a_cmpa_high_copy: assert property (@(posedge clk) disable iff (!rst_b)
    wrDone && paddr == tpc_pkg::OFF_CMPA_HI
    |=> compareAValue == {$past(pwdata[HI_W-1:0]), $past(byteBuffer)})
    else $error("compare a commit wrong");

  // Compare A moves on nothing but its high byte write
  a_cmpa_hold: assert property (@(posedge clk) disable iff (!rst_b)
    !(wrDone && paddr == tpc_pkg::OFF_CMPA_HI) |=> $stable(compareAValue))
    else $error("compare a moved");

  // Compare B moves on nothing but its high byte write
  a_cmpb_hold: assert property (@(posedge clk) disable iff (!rst_b)
    !(wrDone && paddr == tpc_pkg::OFF_CMPB_HI) |=> $stable(compareBValue))
    else $error("compare b moved");

  // Compare A high read freezes its low byte in the buffer
  a_cmpa_read_cap: assert property (@(posedge clk) disable iff (!rst_b)
    rdDone && paddr == tpc_pkg::OFF_CMPA_HI |=> byteBuffer == $past(compareAValue[7:0]))
    else $error("compare a low not captured");

  // Compare B high read freezes its low byte in the buffer
  a_cmpb_read_cap: assert property (@(posedge clk) disable iff (!rst_b)
    rdDone && paddr == tpc_pkg::OFF_CMPB_HI |=> byteBuffer == $past(compareBValue[7:0]))
    else $error("compare b low not captured");

  // Without a completed access the buffer holds
  a_buffer_idle: assert property (@(posedge clk) disable iff (!rst_b)
    !accessDone |=> $stable(byteBuffer))
    else $error("buffer moved while idle");

  // The counter is read only, so writes to it leave the buffer alone
  a_count_write_ign: assert property (@(posedge clk) disable iff (!rst_b)
    wrDone && (paddr == tpc_pkg::OFF_CNT_LO || paddr == tpc_pkg::OFF_CNT_HI)
    |=> $stable(byteBuffer))
    else $error("counter write moved buffer");

  // Counter high read returns the live high bits
  a_count_hi_read: assert property (@(posedge clk) disable iff (!rst_b)
    psel && !penable && !pwrite && paddr == tpc_pkg::OFF_CNT_HI
    |=> prdata[HI_W-1:0] == $past(countValue[VALUE_W-1:8]))
    else $error("counter high read wrong");

  // Compare B low read returns the buffer, not the live byte
  a_cmpb_low_read: assert property (@(posedge clk) disable iff (!rst_b)
    psel && !penable && !pwrite && paddr == tpc_pkg::OFF_CMPB_LO
    |=> prdata == {24'h000000, $past(byteBuffer)})
    else $error("compare b low read wrong");

  // ************************************************************
  // Bus response checks
  // ************************************************************
  // Every setup cycle is answered in the following access cycle
  a_ready_setup: assert property (@(posedge clk) disable iff (!rst_b)
    psel && !penable |=> pready)
    else $error("setup not answered");

  // Ready is a single cycle pulse
  a_ready_pulse: assert property (@(posedge clk) disable iff (!rst_b)
    pready |=> !pready)
    else $error("ready held too long");

  // Addresses past the bank are refused with zero data
  a_err_refuse: assert property (@(posedge clk) disable iff (!rst_b)
    psel && !penable && paddr > tpc_pkg::OFF_CMPB_HI |=> pslverr && prdata == 32'h00000000)
    else $error("unmapped address not refused");

endmodule : tpc_bank

// [tb/tpc_bank_bench.sv]
/*
  Self-checking bench for the pin routing and byte buffer register bank.
  Assumes the four-timer variant with 16-bit values and a zero-wait APB slave.
*/
`timescale 1ns/10ps
module tpc_bank_bench;
  // Expected result of one APB transfer
  typedef struct packed {logic rd; logic err; logic [31:0] data;} tpc_exp_s;
  logic clk, rst_b, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, lfsr;
  logic [15:0] countValue, compareAValue, compareBValue, v, old;
  tpc_pkg::tpc_pins_s pinEnable;
  logic [7:0] r0, r1; // Routing register model
  tpc_exp_s expQ[$]; // Notes from driver to monitor
  tpc_exp_s x;
  int errors, n_checks, cycles;

  tpc_bank #(.VARIANT(tpc_pkg::VAR_FOUR), .VALUE_W(16)) DUT (.clk(clk), .rst_b(rst_b),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .countValue(countValue),
    .compareAValue(compareAValue), .compareBValue(compareBValue), .pinEnable(pinEnable));

  // ************************************************************
  // Helpers
  // ************************************************************
  function automatic logic [31:0] nextRand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nextRand

  // Pin enables expected from the two routing registers
  function automatic logic [11:0] pinsOf(input logic [7:0] a, input logic [7:0] b);
    return {a[7:4], a[1:0], 2'b00, b[1:0], b[5:4]};
  endfunction : pinsOf

  task automatic checkWord(input string what, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask : checkWord

  task automatic checkPins(input logic [11:0] e);
    n_checks++;
    if (pinEnable !== e) begin
      errors++;
      $display("wrong value pinEnable expected %h seen %h", e, pinEnable);
    end
  endtask : checkPins

  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] e, input logic err);
    expQ.push_back('{rd: !wr, err: err, data: e});
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic end_sim();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_sim

  // ************************************************************
  // Clock, monitor and timeout
  // ************************************************************
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Takes the oldest note whenever a transfer completes
  always @(posedge clk) begin
    if (rst_b && psel && penable && pready === 1'b1) begin
      x = expQ.pop_front();
      checkWord("pslverr", {31'h0, x.err}, {31'h0, pslverr});
      if (x.rd) begin
        checkWord("prdata", x.data, prdata);
      end
    end
  end

  // A hang counts as a mismatch
  always @(posedge clk) begin
    cycles++;
    if (cycles == 4000) begin
      errors++;
      end_sim();
    end
  end

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    rst_b = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    countValue = 16'h0;
    lfsr = 32'hA4B3;
    r0 = 8'h91;
    r1 = 8'h11;
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    for (int pass = 0; pass < 2; pass++) begin
      // Reset values, after power-on and after a mid-run reset
      repeat (2) @(posedge clk);
      @(negedge clk);
      checkPins(pinsOf(r0, r1));
      checkWord("compareA", 32'h0, {16'h0, compareAValue});
      apb(1'b0, tpc_pkg::OFF_ROUTE0, 32'h0, {24'h0, r0}, 1'b0);
      apb(1'b0, tpc_pkg::OFF_ROUTE1, 32'h0, {24'h0, r1}, 1'b0);
      // Routing bits: all ones, all zeros, then random
      for (int i = 0; i < 6; i++) begin
        lfsr = nextRand(lfsr);
        v = (i == 0) ? 16'hFFFF : (i == 1) ? 16'h0 : lfsr[15:0];
        apb(1'b1, tpc_pkg::OFF_ROUTE0, {24'h0, v[7:0]}, 32'h0, 1'b0);
        apb(1'b1, tpc_pkg::OFF_ROUTE1, {24'h0, v[15:8]}, 32'h0, 1'b0);
        r0 = v[7:0] & tpc_pkg::MASK0_WIDE;
        r1 = v[15:8] & tpc_pkg::MASK1_FOUR;
        apb(1'b0, tpc_pkg::OFF_ROUTE0, 32'h0, {24'h0, r0}, 1'b0);
        apb(1'b0, tpc_pkg::OFF_ROUTE1, 32'h0, {24'h0, r1}, 1'b0);
        @(negedge clk);
        checkPins(pinsOf(r0, r1));
      end
      // Compare pairs: low write buffers, high write commits
      for (int k = 0; k < 2; k++) begin
        lfsr = nextRand(lfsr);
        v = lfsr[15:0];
        old = k ? compareBValue : compareAValue;
        apb(1'b1, k ? tpc_pkg::OFF_CMPB_LO : tpc_pkg::OFF_CMPA_LO, {24'h0, v[7:0]}, 32'h0,
            1'b0);
        @(negedge clk);
        checkWord("compare", {16'h0, old}, {16'h0, k ? compareBValue : compareAValue});
        apb(1'b1, k ? tpc_pkg::OFF_CMPB_HI : tpc_pkg::OFF_CMPA_HI, {24'h0, v[15:8]}, 32'h0, 1'b0);
        @(negedge clk);
        checkWord("compare", {16'h0, v}, {16'h0, k ? compareBValue : compareAValue});
        apb(1'b0, k ? tpc_pkg::OFF_CMPB_HI : tpc_pkg::OFF_CMPA_HI, 32'h0, {24'h0, v[15:8]}, 1'b0);
        apb(1'b0, k ? tpc_pkg::OFF_CMPB_LO : tpc_pkg::OFF_CMPA_LO, 32'h0, {24'h0, v[7:0]}, 1'b0);
      end
      // Counter: low byte frozen at the high read, shared buffer
      lfsr = nextRand(lfsr);
      @(posedge clk);
      countValue <= lfsr[15:0];
      v = lfsr[15:0];
      apb(1'b0, tpc_pkg::OFF_CNT_HI, 32'h0, {24'h0, v[15:8]}, 1'b0);
      @(posedge clk);
      countValue <= ~v;
      apb(1'b0, tpc_pkg::OFF_CNT_LO, 32'h0, {24'h0, v[7:0]}, 1'b0);
      apb(1'b0, tpc_pkg::OFF_CMPA_LO, 32'h0, {24'h0, v[7:0]}, 1'b0);
      // Unmapped and unaligned addresses are refused
      apb(1'b1, 8'h20, 32'hFFFFFFFF, 32'h0, 1'b1);
      apb(1'b0, 8'h20, 32'h0, 32'h0, 1'b1);
      apb(1'b0, 8'h02, 32'h0, 32'h0, 1'b1);
      // Mid-run reset restores the reset values
      @(posedge clk);
      rst_b <= 1'b0;
      @(posedge clk);
      rst_b <= 1'b1;
      r0 = 8'h91;
      r1 = 8'h11;
    end
    end_sim();
  end
endmodule : tpc_bank_bench
